/* File: verilog/bcpm_pkg.sv */
`default_nettype none
package bcpm_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CAP_PTR   = 8'h34;
   localparam logic [7:0] OFS_INT_BCTL  = 8'h3C;
   localparam logic [7:0] OFS_PM_HDR    = 8'h40;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int INT_PIN_LSB  = 8;
   localparam int BCTL_LSB     = 16;
   localparam int BIT_PERR     = 0;
   localparam int BIT_SERR     = 1;
   localparam int BIT_ISA      = 2;
   localparam int BIT_VGA      = 3;
   localparam int BIT_VGA16    = 4;
   localparam int BIT_SBR      = 6;
   localparam int PM_NEXT_LSB  = 8;
   localparam int PM_REV_LSB   = 16;
   localparam int PM_LOAD_LSB  = 21;
   // ------------------------------------------------------------
   // Reset and fixed values
   // ------------------------------------------------------------
   localparam logic [7:0]  CAP_PTR_VAL   = 8'h40;
   localparam logic [7:0]  INT_PIN_RST   = 8'h00;
   localparam logic [6:0]  BCTL_RST      = 7'h00;
   localparam logic [6:0]  BCTL_WR_MASK  = 7'h5F;
   localparam logic [7:0]  PM_CAP_ID     = 8'h01;
   localparam logic [7:0]  PM_NEXT_UP    = 8'h5C;
   localparam logic [7:0]  PM_NEXT_DN    = 8'h4C;
   localparam logic [2:0]  PM_REV        = 3'h3;
   // DSI 0, aux current 111b, D1 1, D2 1, event support 11111b
   localparam logic [10:0] PM_LOAD_RST   = 11'h7FE;
   // ------------------------------------------------------------
   // Legacy graphics decode ranges
   // ------------------------------------------------------------
   localparam logic [31:0] VGA_MEM_LO    = 32'h000A_0000;
   localparam logic [31:0] VGA_MEM_HI    = 32'h000B_FFFF;
   localparam logic [9:0]  VGA_IO_A_LO   = 10'h3B0;
   localparam logic [9:0]  VGA_IO_A_HI   = 10'h3BB;
   localparam logic [9:0]  VGA_IO_B_LO   = 10'h3C0;
   localparam logic [9:0]  VGA_IO_B_HI   = 10'h3DF;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bcpm_bus_t;
   typedef struct packed {
      logic        valid;
      logic        sel_pm;
      logic [31:0] data;
   } bcpm_load_t;
   typedef struct packed {
      logic        valid;
      logic [1:0]  kind;
   } bcpm_err_t;
   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic        in_window;
      logic [31:0] addr;
   } bcpm_query_t;
   typedef struct packed {
      logic        valid;
      logic        fwd;
      logic        vga;
   } bcpm_fwd_t;
endpackage
`default_nettype wire

/* File: verilog/bcpm_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module bcpm_regs #(
   parameter bit IS_UPSTREAM = 1'b0,
   parameter int NUM_DOWN    = 2
) (
   // Clock, reset, enable
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // Configuration register port
   input  wire bcpm_pkg::bcpm_bus_t   bus,
   output var  logic [31:0]           rdata,
   // Default override from serial port or boot memory
   input  wire bcpm_pkg::bcpm_load_t  load,
   // Reset request from upstream port (downstream instance only)
   input  wire logic                  up_sbr,
   // Link and device resets
   output var  logic                  hot_reset,
   output var  logic [NUM_DOWN-1:0]   port_rst_n,
   // Error and poison handling
   input  wire bcpm_pkg::bcpm_err_t   err_in,
   input  wire logic                  poison_in,
   output var  bcpm_pkg::bcpm_err_t   err_fwd,
   output var  logic                  poison_report,
   // Address forwarding query
   input  wire bcpm_pkg::bcpm_query_t query,
   output var  bcpm_pkg::bcpm_fwd_t   fwd
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]  int_pin;
   logic [6:0]  bctl;
   logic [10:0] pm_load;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic hit_cap  = (bus.addr == bcpm_pkg::OFS_CAP_PTR);
   wire logic hit_bctl = (bus.addr == bcpm_pkg::OFS_INT_BCTL);
   wire logic hit_pm   = (bus.addr == bcpm_pkg::OFS_PM_HDR);
   wire logic wr_bctl  = bus.wr && hit_bctl;

   wire logic [6:0] wr_field =
      bus.wdata[bcpm_pkg::BCTL_LSB +: 7];
   wire logic [6:0] next_bctl =
      (bctl & ~bcpm_pkg::BCTL_WR_MASK) |
      (wr_field & bcpm_pkg::BCTL_WR_MASK);

   wire logic load_int = load.valid && !load.sel_pm && !IS_UPSTREAM;
   wire logic load_pm  = load.valid && load.sel_pm;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   wire logic [7:0] next_ptr =
      IS_UPSTREAM ? bcpm_pkg::PM_NEXT_UP
                  : bcpm_pkg::PM_NEXT_DN;

   // Bits 21 and 23 to 31 of the bridge word always read zero
   wire logic [31:0] rd_bctl = {9'h000, bctl[6], 1'b0, bctl[4:0],
                                int_pin, 8'h00};
   wire logic [31:0] rd_pm   = {pm_load, 2'b00,
                                bcpm_pkg::PM_REV,
                                next_ptr,
                                bcpm_pkg::PM_CAP_ID};
   wire logic [31:0] rd_cap  = {24'h00_0000,
                                bcpm_pkg::CAP_PTR_VAL};
   wire logic [31:0] next_rdata =
      hit_cap  ? rd_cap  :
      hit_bctl ? rd_bctl :
      hit_pm   ? rd_pm   : 32'h0000_0000;

   // ------------------------------------------------------------
   // Reset fan-out
   // ------------------------------------------------------------
   wire logic rst_req = bctl[bcpm_pkg::BIT_SBR] ||
                        (!IS_UPSTREAM && up_sbr);
   wire logic [NUM_DOWN-1:0] next_port_rst_n =
      IS_UPSTREAM ? {NUM_DOWN{!bctl[bcpm_pkg::BIT_SBR]}}
                  : {{(NUM_DOWN-1){1'b1}}, !rst_req};

   // ------------------------------------------------------------
   // Forwarding decode
   // ------------------------------------------------------------
   wire logic [9:0] low10   = query.addr[9:0];
   wire logic first_64k     = (query.addr[31:16] == 16'h0000);
   wire logic isa_blocked   = bctl[bcpm_pkg::BIT_ISA] && first_64k &&
                              (query.addr[9:8] == 2'b00);
   wire logic vga_io_low    =
      ((low10 >= bcpm_pkg::VGA_IO_A_LO) &&
       (low10 <= bcpm_pkg::VGA_IO_A_HI)) ||
      ((low10 >= bcpm_pkg::VGA_IO_B_LO) &&
       (low10 <= bcpm_pkg::VGA_IO_B_HI));
   wire logic vga_io_hit    = first_64k && vga_io_low &&
      (!bctl[bcpm_pkg::BIT_VGA16] ||
       (query.addr[15:10] == 6'h00));
   wire logic vga_mem_hit   = (query.addr >= bcpm_pkg::VGA_MEM_LO) &&
                              (query.addr <= bcpm_pkg::VGA_MEM_HI);
   wire logic next_vga      = bctl[bcpm_pkg::BIT_VGA] &&
      (query.is_io ? vga_io_hit : vga_mem_hit);
   wire logic next_fwd      = next_vga ||
      (query.in_window && !(query.is_io && isa_blocked));

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_pin <= bcpm_pkg::INT_PIN_RST;
         bctl    <= bcpm_pkg::BCTL_RST;
         pm_load <= bcpm_pkg::PM_LOAD_RST;
      end else if (ce) begin
         if (wr_bctl) begin
            bctl <= next_bctl;
         end
         if (load_int) begin
            int_pin <= load.data[bcpm_pkg::INT_PIN_LSB +: 8];
         end
         if (load_pm) begin
            pm_load <= load.data[bcpm_pkg::PM_LOAD_LSB +: 11];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (ce && bus.rd) begin
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hot_reset     <= 1'b0;
         port_rst_n    <= {NUM_DOWN{1'b1}};
         err_fwd       <= '0;
         poison_report <= 1'b0;
         fwd           <= '0;
      end else if (ce) begin
         hot_reset     <= bctl[bcpm_pkg::BIT_SBR];
         port_rst_n    <= next_port_rst_n;
         err_fwd.valid <= err_in.valid &&
                          bctl[bcpm_pkg::BIT_SERR];
         err_fwd.kind  <= err_in.kind;
         poison_report <= poison_in &&
                          bctl[bcpm_pkg::BIT_PERR];
         fwd.valid     <= query.valid;
         fwd.fwd       <= query.valid && next_fwd;
         fwd.vga       <= query.valid && next_vga;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_cap_id;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && hit_pm |=> rdata[7:0] == 8'h01 &&
         rdata[15:8] == (IS_UPSTREAM ? 8'h5C : 8'h4C);
   endproperty
   a_cap_id: assert property (p_cap_id)
      else $error("power header id or next pointer wrong");

   property p_pm_rev;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && hit_pm |=> rdata[20:16] == 5'b00011;
   endproperty
   a_pm_rev: assert property (p_pm_rev)
      else $error("power revision or clock flag wrong");

   property p_cap_ptr;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && hit_cap |=> rdata == 32'h0000_0040;
   endproperty
   a_cap_ptr: assert property (p_cap_ptr)
      else $error("capability pointer not 40h");

   property p_bctl_ro;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && hit_bctl |=>
         rdata[31:23] == 9'h000 && !rdata[21] && rdata[7:0] == 8'h00;
   endproperty
   a_bctl_ro: assert property (p_bctl_ro)
      else $error("hardwired bridge control bit set");

   property p_wr_rw;
      @(posedge clk_sys) disable iff (rst)
      ce && wr_bctl |=> bctl == ($past(bus.wdata[22:16]) & 7'h5F);
   endproperty
   a_wr_rw: assert property (p_wr_rw)
      else $error("bridge control write not taken");

   property p_pm_keep;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.wr && !load.valid |=> $stable(pm_load) && $stable(int_pin);
   endproperty
   a_pm_keep: assert property (p_pm_keep)
      else $error("write changed read-only field");

   property p_port_rst;
      @(posedge clk_sys) disable iff (rst)
      ce && bctl[6] |=> !port_rst_n[0] && hot_reset;
   endproperty
   a_port_rst: assert property (p_port_rst)
      else $error("port reset not asserted");

   property p_port_rel;
      @(posedge clk_sys) disable iff (rst)
      ce && !rst_req |=> port_rst_n == {NUM_DOWN{1'b1}};
   endproperty
   a_port_rel: assert property (p_port_rel)
      else $error("port reset not released");

   property p_err_gate;
      @(posedge clk_sys) disable iff (rst)
      ce && err_in.valid |=> err_fwd.valid == $past(bctl[1]);
   endproperty
   a_err_gate: assert property (p_err_gate)
      else $error("error forwarding gate wrong");

   property p_poison;
      @(posedge clk_sys) disable iff (rst)
      ce && poison_in |=> poison_report == $past(bctl[0]);
   endproperty
   a_poison: assert property (p_poison)
      else $error("poison report gate wrong");

   property p_isa;
      @(posedge clk_sys) disable iff (rst)
      ce && query.valid && query.is_io && bctl[2] && !bctl[3] &&
         query.addr[31:16] == 16'h0000 && query.addr[9:8] == 2'b00
         |=> fwd.valid && !fwd.fwd;
   endproperty
   a_isa: assert property (p_isa)
      else $error("low I/O block forwarded");

   property p_vga_mem;
      @(posedge clk_sys) disable iff (rst)
      ce && query.valid && !query.is_io &&
         query.addr[31:17] == 15'h0005 |=> fwd.vga == $past(bctl[3]);
   endproperty
   a_vga_mem: assert property (p_vga_mem)
      else $error("graphics memory decode wrong");

   property p_vga_io16;
      @(posedge clk_sys) disable iff (rst)
      ce && query.valid && query.is_io && bctl[4] &&
         query.addr[15:10] != 6'h00 |=> !fwd.vga;
   endproperty
   a_vga_io16: assert property (p_vga_io16)
      else $error("16-bit graphics decode aliased");

   property p_load_pm;
      @(posedge clk_sys) disable iff (rst)
      ce && load_pm |=> pm_load == $past(load.data[31:21]);
   endproperty
   a_load_pm: assert property (p_load_pm)
      else $error("capability default override not taken");

   property p_load_int;
      @(posedge clk_sys) disable iff (rst)
      ce && load.valid && !load.sel_pm |=> int_pin ==
         (IS_UPSTREAM ? $past(int_pin) : $past(load.data[15:8]));
   endproperty
   a_load_int: assert property (p_load_int)
      else $error("interrupt pin override wrong");

   property p_pm_dflt;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && hit_pm |=> rdata[31:21] == $past(pm_load);
   endproperty
   a_pm_dflt: assert property (p_pm_dflt)
      else $error("power support fields not shown");

   property p_hot_rel;
      @(posedge clk_sys) disable iff (rst)
      ce && !bctl[6] |=> !hot_reset;
   endproperty
   a_hot_rel: assert property (p_hot_rel)
      else $error("hot reset not released");

   property p_err_kind;
      @(posedge clk_sys) disable iff (rst)
      ce && err_in.valid && bctl[1] |=> err_fwd.kind == $past(err_in.kind);
   endproperty
   a_err_kind: assert property (p_err_kind)
      else $error("forwarded error kind wrong");

   property p_unmapped;
      @(posedge clk_sys) disable iff (rst)
      ce && bus.rd && !(hit_cap || hit_bctl || hit_pm) |=> rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address read not zero");

   property p_vga_io;
      @(posedge clk_sys) disable iff (rst)
      ce && query.valid && query.is_io && bctl[3] &&
         query.addr == 32'h0000_03C0 |=> fwd.vga && fwd.fwd;
   endproperty
   a_vga_io: assert property (p_vga_io)
      else $error("graphics I/O address not forwarded");

   property p_fwd_valid;
      @(posedge clk_sys) disable iff (rst)
      ce |=> fwd.valid == $past(query.valid);
   endproperty
   a_fwd_valid: assert property (p_fwd_valid)
      else $error("forwarding answer not one cycle after query");

   property p_freeze;
      @(posedge clk_sys) disable iff (rst)
      !ce |=> $stable(bctl) && $stable(rdata) && $stable(port_rst_n);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

endmodule // bcpm_regs
`default_nettype wire

/* File: verif/bcpm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bcpm_host (
   // Clock
   input  wire logic                clk_sys,
   // Configuration port
   output var  bcpm_pkg::bcpm_bus_t bus,
   input  wire logic [31:0]         rdata
);
   initial bus = '0;
   // Released address and data lines show the inverse, never the last value; both strobes go low
   task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
      @(negedge clk_sys);
      d = rdata;
   endtask
endmodule // bcpm_host
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ---------------------------------------------
   // Signals and models
   // ---------------------------------------------
   logic                  clk_sys, rst, ce, up_sbr, poison_in;
   bcpm_pkg::bcpm_bus_t   bus;
   bcpm_pkg::bcpm_load_t  load;
   bcpm_pkg::bcpm_err_t   err_in, err_fwd;
   bcpm_pkg::bcpm_query_t query;
   bcpm_pkg::bcpm_fwd_t   fwd;
   logic [31:0]           rdata, rdata_up, rd_v;
   logic                  hot_reset, hot_up, poison_report;
   logic [1:0]            port_rst_n, prst_up;
   int                    miscompares, total_checks;
   logic [15:0]           lfsr;
   logic [6:0]            bm;
   logic [7:0]            pin_m;
   logic [10:0]           pm_m;
   logic [31:0]           qa [14] = '{32'h0000_03B0, 32'h0000_03BB,
      32'h0000_03BC, 32'h0000_03C0, 32'h0000_03DF, 32'h0000_03E0,
      32'h0000_17C0, 32'h0001_03B0, 32'h0000_0480, 32'h0000_0500,
      32'h000A_0000, 32'h000B_FFFF, 32'h0009_FFFF, 32'h000C_0000};
   bcpm_regs #(.IS_UPSTREAM(1'b0), .NUM_DOWN(2)) i_bcpm_regs (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
      .load(load), .up_sbr(up_sbr), .hot_reset(hot_reset),
      .port_rst_n(port_rst_n), .err_in(err_in), .poison_in(poison_in),
      .err_fwd(err_fwd), .poison_report(poison_report), .query(query),
      .fwd(fwd));
   bcpm_regs #(.IS_UPSTREAM(1'b1), .NUM_DOWN(2)) i_bcpm_regs_up (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata_up),
      .load(load), .up_sbr(1'b0), .hot_reset(hot_up),
      .port_rst_n(prst_up), .err_in(err_in), .poison_in(poison_in),
      .err_fwd(), .poison_report(), .query(query), .fwd());
   bcpm_host i_bcpm_host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ---------------------------------------------
   // Expectations and helpers
   // ---------------------------------------------
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
      return {lfsr, lfsr ^ 16'hA5C3};
   endfunction
   function automatic logic [31:0] exp_3c(input logic up);
      return {9'h000, bm[6], 1'b0, bm[4:0], up ? 8'h00 : pin_m, 8'h00};
   endfunction
   function automatic logic [31:0] exp_pm(input logic up);
      return {pm_m, 2'b00, 3'h3, up ? 8'h5C : 8'h4C, 8'h01};
   endfunction
   function automatic logic vga_hit(input logic io, input logic [31:0] a);
      if (!io) return a >= 32'h000A_0000 && a <= 32'h000B_FFFF;
      return a[31:16] == 16'h0000 && (!bm[4] || a[15:10] == 6'h00) &&
         ((a[9:0] >= 10'h3B0 && a[9:0] <= 10'h3BB) ||
          (a[9:0] >= 10'h3C0 && a[9:0] <= 10'h3DF));
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic cfg_chk(input logic [7:0] a, input logic [31:0] e);
      i_bcpm_host.cfg_rd(a, rd_v);
      check(rd_v, e);
   endtask
   task automatic wr_bctl(input logic [31:0] d, input logic sb);
      @(posedge clk_sys);
      up_sbr <= sb;
      i_bcpm_host.cfg_wr(8'h3C, d);
      bm = d[22:16] & 7'h5F;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(hot_reset, bm[6]);
      chk1(hot_up, bm[6]);
      check({30'h0, port_rst_n}, {30'h0, 1'b1, !(bm[6] | sb)});
      check({30'h0, prst_up}, {30'h0, {2{!bm[6]}}});
      cfg_chk(8'h3C, exp_3c(1'b0));
      check(rdata_up, exp_3c(1'b1));
   endtask
   task automatic sec(input logic [31:0] r, input logic io,
                      input logic [31:0] a);
      logic v;
      @(posedge clk_sys);
      err_in <= '{valid: r[0], kind: 2'(r[9:8] % 3)};
      poison_in <= r[1];
      query <= '{valid: 1'b1, is_io: io, in_window: r[2], addr: a};
      @(posedge clk_sys);
      err_in <= '{valid: 1'b0, kind: ~r[9:8]};
      poison_in <= 1'b0;
      query <= '{valid: 1'b0, is_io: ~io, in_window: ~r[2], addr: ~a};
      @(negedge clk_sys);
      v = bm[3] & vga_hit(io, a);
      chk1(err_fwd.valid, r[0] & bm[1]);
      if (r[0] & bm[1]) check(32'(err_fwd.kind), r[9:8] % 3);
      chk1(poison_report, r[1] & bm[0]);
      chk1(fwd.valid, 1'b1);
      chk1(fwd.vga, v);
      chk1(fwd.fwd, v | (r[2] & !(io & bm[2] & a[31:16] == 16'h0000 &
         a[9:8] == 2'b00)));
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      repeat (30000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end
   initial begin
      {miscompares, total_checks, lfsr} = {32'd0, 32'd0, 16'h000C};
      {rst, ce, up_sbr, poison_in} = 4'b1100;
      {load, err_in, query} = '0;
      {bm, pin_m, pm_m} = {7'h00, 8'h00, 11'h7FE};
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      cfg_chk(8'h34, 32'h0000_0040);
      cfg_chk(8'h3C, exp_3c(1'b0));
      cfg_chk(8'h40, exp_pm(1'b0));
      check(rdata_up, exp_pm(1'b1));
      cfg_chk(8'h48, 32'h0000_0000);
      $display("test reset done");
      wr_bctl(32'hFFFF_FFFF, 1'b0);
      repeat (16) begin
         rd_v = rnd();
         wr_bctl(rd_v, rd_v[5]);
         i_bcpm_host.cfg_wr(8'h40, ~rd_v);
         i_bcpm_host.cfg_wr(8'h34, rd_v);
         cfg_chk(8'h40, exp_pm(1'b0));
         cfg_chk(8'h34, 32'h0000_0040);
      end
      @(posedge clk_sys);
      ce <= 1'b0;
      i_bcpm_host.cfg_wr(8'h3C, ~{9'h000, bm, 16'h0000});
      @(posedge clk_sys);
      ce <= 1'b1;
      cfg_chk(8'h3C, exp_3c(1'b0));
      $display("test writes done");
      for (int i = 0; i < 6; i++) begin
         rd_v = rnd();
         @(posedge clk_sys);
         load <= '{valid: 1'b1, sel_pm: i[0], data: rd_v};
         @(posedge clk_sys);
         load <= '{valid: 1'b0, sel_pm: ~i[0], data: ~rd_v};
         if (i[0]) pm_m = rd_v[31:21];
         else pin_m = rd_v[15:8];
         cfg_chk(8'h40, exp_pm(1'b0));
         check(rdata_up, exp_pm(1'b1));
         cfg_chk(8'h3C, exp_3c(1'b0));
         check(rdata_up, exp_3c(1'b1));
      end
      $display("test load done");
      for (int s = 0; s < 32; s++) begin
         wr_bctl({11'h000, 5'(s), 16'h0000}, 1'b0);
         for (int q = 0; q < 14; q++) sec(rnd(), q < 10, qa[q]);
         repeat (3) begin
            rd_v = rnd();
            sec(rnd(), rd_v[31], {14'h0000, rd_v[17:0]});
         end
      end
      $display("test forwarding done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
